// *** rtl/csag_consts.svh ***
`ifndef CSAG_CONSTS_SVH
`define CSAG_CONSTS_SVH

// -------------------------------------------------------------
// widths
// -------------------------------------------------------------
`define CSAG_WORD_W 16
`define CSAG_KEY_WORDS 8
`define CSAG_IDX_W 3
`define CSAG_PWD_W 128
`define CSAG_ADDR_W 22

// -------------------------------------------------------------
// status and control word layout
// -------------------------------------------------------------
`define CSAG_FORCE_BIT 15
`define CSAG_LOCK_BIT 0
`define CSAG_RSVD_LO 1
`define CSAG_RSVD_HI 6
`define CSAG_RSVD_VAL 6'h17

// -------------------------------------------------------------
// fill values
// -------------------------------------------------------------
`define CSAG_READ_NONE 8'h00
`define CSAG_DATA_ZERO 16'h0000

`endif

// *** rtl/csag_pkg.sv ***
`include "csag_consts.svh"

package csag_pkg;

   // -------------------------------------------------------------
   // lock state, gray coded along locked -> armed -> unlocked
   // -------------------------------------------------------------
   typedef enum logic [1:0] {
      CSAG_LOCKED   = 2'h0,
      CSAG_ARMED    = 2'h1,
      CSAG_UNLOCKED = 2'h3
   } csag_state_t;

   // -------------------------------------------------------------
   // request from cpu or debug port
   // -------------------------------------------------------------
   typedef struct packed {
      logic valid;
      logic fetch;
      logic write;
      logic debug;
      logic from_secure;
      logic target_secure;
      logic [`CSAG_ADDR_W-1:0] addr;
      logic [`CSAG_WORD_W-1:0] wdata;
   } csag_req_t;

   // -------------------------------------------------------------
   // request passed on to the memory arrays
   // -------------------------------------------------------------
   typedef struct packed {
      logic en;
      logic we;
      logic [`CSAG_ADDR_W-1:0] addr;
      logic [`CSAG_WORD_W-1:0] wdata;
   } csag_mem_t;

endpackage

// *** rtl/csag_key_store.sv ***
`include "csag_consts.svh"

module csag_key_store #(
   parameter int WORDS = `CSAG_KEY_WORDS,
   parameter int WIDTH = `CSAG_WORD_W
) (
   input wire logic mclk_in,
   input wire logic rstn_in,
   input wire logic clear_in,
   input wire logic wr_in,
   input wire logic [$clog2(WORDS)-1:0] idx_in,
   input wire logic [WIDTH-1:0] data_in,
   output logic [WORDS*WIDTH-1:0] keys_out,
   output logic [WORDS-1:0] written_out
);
   localparam int IDX_W = $clog2(WORDS);

   // refuse sizes the index decode cannot serve
   if (WORDS < 2 || WIDTH < 1 || (1 << IDX_W) != WORDS) begin : g_bad_size
      $error("csag_key_store: WORDS must be a power of two, WIDTH at least one");
   end

   // -------------------------------------------------------------
   // one key word per entry, clear wins over write
   // -------------------------------------------------------------
   for (genvar w = 0; w < WORDS; w++) begin : g_word
      logic [WIDTH-1:0] word_reg;
      logic [WIDTH-1:0] word_next;
      logic seen_reg;
      logic seen_next;

      always_comb begin
         word_next = word_reg;
         seen_next = seen_reg;
         if (clear_in) begin
            word_next = '0;
            seen_next = 1'b0;
         end else if (wr_in && idx_in == IDX_W'(w)) begin
            word_next = data_in;
            seen_next = 1'b1;
         end
      end

      always_ff @(posedge mclk_in) begin
         if (!rstn_in) begin
            word_reg <= '0;
            seen_reg <= 1'b0;
         end else begin
            word_reg <= word_next;
            seen_reg <= seen_next;
         end
      end

      assign keys_out[w*WIDTH +: WIDTH] = word_reg;
      assign written_out[w] = seen_reg;
   end

endmodule

// *** rtl/csag_gate.sv ***
// Behaviour
// R1 - every reset leaves the gate locked until the unlock sequence succeeds
// R2 - cpu instruction fetches from secure memory are always granted
// R3 - while locked, writes to secure memory from unsecure code are blocked
// R4 - while locked, data reads of secure memory from unsecure code are blocked
// R5 - while locked, every debug access to secure memory is refused
// R6 - while unlocked, cpu and debug get full secure memory access
// R7 - while locked, secure data access only for code fetched from secure memory
// R8 - an all zero password keeps the gate locked for good
// R9 - an all ones password unlocks without any key written
// R10 - software keeps the reserved flash region at zero and unused
// R11 - eight password reads then eight key writes; unlock on exact match
// R12 - finishing the password reads unlocks at once when password is all ones
// R13 - writing one to bit 15 clears keys and relocks; bit reads zero
// R14 - status bit 0 reads one while locked, zero while unlocked
// R15 - blocked reads return zero, blocked writes are dropped without side effects
`include "csag_consts.svh"

module csag_gate
   import csag_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rstn_in,
   input wire logic [`CSAG_PWD_W-1:0] password_in,
   input wire logic pwd_read_in,
   input wire logic [`CSAG_IDX_W-1:0] pwd_index_in,
   input wire logic protected_write_enable_in,
   input wire logic key_write_in,
   input wire logic [`CSAG_IDX_W-1:0] key_index_in,
   input wire logic [`CSAG_WORD_W-1:0] key_data_in,
   input wire logic ctrl_write_in,
   input wire logic [`CSAG_WORD_W-1:0] ctrl_data_in,
   input wire csag_req_t req_in,
   output csag_mem_t mem_out,
   input wire logic [`CSAG_WORD_W-1:0] mem_rdata_in,
   output logic [`CSAG_WORD_W-1:0] rdata_out,
   output logic rvalid_out,
   output logic denied_out,
   output logic [`CSAG_WORD_W-1:0] status_out,
   output logic locked_out
);

   // -------------------------------------------------------------
   // declarations
   // -------------------------------------------------------------
   csag_state_t state_reg;
   csag_state_t state_next;
   logic [`CSAG_KEY_WORDS-1:0] read_mask_reg;
   logic [`CSAG_KEY_WORDS-1:0] read_mask_next;
   logic [`CSAG_WORD_W-1:0] rdata_reg;
   logic [`CSAG_WORD_W-1:0] rdata_next;
   logic rvalid_reg;
   logic rvalid_next;
   logic denied_reg;
   logic denied_next;
   logic [`CSAG_PWD_W-1:0] keys;
   logic [`CSAG_KEY_WORDS-1:0] keys_written;
   logic locked;
   logic force_lock;
   logic key_wr;
   logic key_clear;
   logic reads_done;
   logic pwd_ones;
   logic pwd_zero;
   logic key_match;
   logic grant;
   logic secure_data;

   assign locked = (state_reg != CSAG_UNLOCKED);
   assign pwd_ones = &password_in;
   assign pwd_zero = ~|password_in;

   // -------------------------------------------------------------
   // control writes and key words
   // -------------------------------------------------------------
   // R13 force relock
   assign force_lock = ctrl_write_in && protected_write_enable_in &&
                       ctrl_data_in[`CSAG_FORCE_BIT];
   assign key_wr = key_write_in && protected_write_enable_in;
   // R11 fresh keys after reads
   assign key_clear = force_lock || (state_reg == CSAG_LOCKED && reads_done);

   csag_key_store #(
      .WORDS(`CSAG_KEY_WORDS),
      .WIDTH(`CSAG_WORD_W)
   ) u_keys (
      .mclk_in(mclk_in),
      .rstn_in(rstn_in),
      .clear_in(key_clear),
      .wr_in(key_wr),
      .idx_in(key_index_in),
      .data_in(key_data_in),
      .keys_out(keys),
      .written_out(keys_written)
   );

   // R8 zero never matches
   assign key_match = (&keys_written) && (keys == password_in) && !pwd_zero;

   // -------------------------------------------------------------
   // lock state machine
   // -------------------------------------------------------------
   always_comb begin
      read_mask_next = read_mask_reg;
      state_next = state_reg;
      reads_done = 1'b0;
      if (state_reg == CSAG_LOCKED && pwd_read_in) begin
         read_mask_next = read_mask_reg | (`CSAG_KEY_WORDS'(1) << pwd_index_in);
      end
      if (state_reg == CSAG_LOCKED) begin
         reads_done = &read_mask_next;
      end
      case (state_reg)
         CSAG_LOCKED: begin
            // R9 R12 ones unlock on reads
            if (reads_done && pwd_ones) begin
               state_next = CSAG_UNLOCKED;
            end else if (reads_done) begin
               state_next = CSAG_ARMED;
            end
         end
         CSAG_ARMED: begin
            // R11 key compare
            if (key_match) begin
               state_next = CSAG_UNLOCKED;
            end
         end
         CSAG_UNLOCKED: begin
            state_next = CSAG_UNLOCKED;
         end
         default: begin
            state_next = CSAG_LOCKED;
         end
      endcase
      if (state_next != CSAG_LOCKED) begin
         read_mask_next = `CSAG_READ_NONE;
      end
      // R13 relock wins
      if (force_lock) begin
         state_next = CSAG_LOCKED;
         read_mask_next = `CSAG_READ_NONE;
      end
   end

   // R1 locked after reset
   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         state_reg <= CSAG_LOCKED;
         read_mask_reg <= `CSAG_READ_NONE;
      end else begin
         state_reg <= state_next;
         read_mask_reg <= read_mask_next;
      end
   end

   // -------------------------------------------------------------
   // access decision
   // -------------------------------------------------------------
   // R7 data from secure code
   assign secure_data = !req_in.debug && !req_in.fetch && req_in.from_secure;

   always_comb begin
      grant = 1'b0;
      if (req_in.valid) begin
         if (!req_in.target_secure) begin
            grant = 1'b1;
         // R2 fetches pass
         end else if (req_in.fetch && !req_in.debug) begin
            grant = 1'b1;
         // R6 unlocked full access
         end else if (!locked) begin
            grant = 1'b1;
         // R3 R4 R5 locked blocks
         end else begin
            grant = secure_data;
         end
      end
   end

   // R15 blocked write dropped
   assign mem_out.en = grant;
   assign mem_out.we = grant && req_in.write;
   assign mem_out.addr = req_in.addr;
   assign mem_out.wdata = req_in.wdata;

   // -------------------------------------------------------------
   // read answer
   // -------------------------------------------------------------
   always_comb begin
      rvalid_next = req_in.valid && !req_in.write;
      denied_next = req_in.valid && !grant;
      rdata_next = `CSAG_DATA_ZERO;
      // R15 blocked read zero
      if (rvalid_next && grant) begin
         rdata_next = mem_rdata_in;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         rdata_reg <= `CSAG_DATA_ZERO;
         rvalid_reg <= 1'b0;
         denied_reg <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
         denied_reg <= denied_next;
      end
   end

   assign rdata_out = rdata_reg;
   assign rvalid_out = rvalid_reg;
   assign denied_out = denied_reg;

   // -------------------------------------------------------------
   // status word
   // -------------------------------------------------------------
   // R14 lock status bit
   always_comb begin
      status_out = `CSAG_DATA_ZERO;
      status_out[`CSAG_LOCK_BIT] = locked;
      status_out[`CSAG_RSVD_HI:`CSAG_RSVD_LO] = `CSAG_RSVD_VAL;
   end
   assign locked_out = locked;

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!rstn_in);

   sequence s_reads_finish;
      state_reg == CSAG_LOCKED && reads_done && !force_lock;
   endsequence

   sequence s_key_accept;
      state_reg == CSAG_ARMED && key_match && !force_lock;
   endsequence

   sequence s_sec_req;
      req_in.valid && req_in.target_secure;
   endsequence

   a_reset_locks: assert property ($rose(rstn_in) |-> status_out[`CSAG_LOCK_BIT]) // R1
      else $error("gate not locked after reset");
   a_fetch_grant: assert property ( // R2
      s_sec_req ##0 (req_in.fetch && !req_in.debug) |-> mem_out.en)
      else $error("secure fetch not granted");
   a_locked_wr_block: assert property ( // R3
      s_sec_req ##0 (locked && req_in.write && !req_in.from_secure) |-> !mem_out.we)
      else $error("unsecure write passed while locked");
   a_locked_rd_block: assert property ( // R4
      s_sec_req ##0 (locked && !req_in.write && !req_in.fetch && !req_in.from_secure)
      |-> !mem_out.en ##1 rdata_out == '0)
      else $error("unsecure read passed while locked");
   a_debug_refuse: assert property ( // R5
      s_sec_req ##0 (locked && req_in.debug) |-> !mem_out.en ##1 denied_out)
      else $error("debug access passed while locked");
   a_unlocked_full: assert property (s_sec_req ##0 !locked |-> mem_out.en) // R6
      else $error("access refused while unlocked");
   a_secure_data: assert property ( // R7
      s_sec_req ##0 (locked && secure_data) |-> mem_out.en)
      else $error("secure code data access refused");
   a_zero_stays: assert property (pwd_zero && locked |=> locked) // R8
      else $error("zero password unlocked");
   a_ones_unlock: assert property (s_reads_finish ##0 pwd_ones |=> !locked_out) // R9 R12
      else $error("all ones password did not unlock");
   a_key_unlock: assert property (s_key_accept |=> !locked_out) // R11
      else $error("matching key did not unlock");
   a_force_relock: assert property ( // R13
      force_lock |=> locked && keys_written == '0 && !status_out[`CSAG_FORCE_BIT])
      else $error("force lock did not relock");
   a_blocked_read: assert property ( // R15
      req_in.valid && !req_in.write && !grant |=> rvalid_out && rdata_out == '0 && denied_out)
      else $error("blocked read returned data");

endmodule

// *** test/csag_mem_model.sv ***
`include "csag_consts.svh"

module csag_mem_model
   import csag_pkg::*;
(
   input wire logic mclk_in,
   input wire csag_mem_t mem_in,
   output logic [`CSAG_WORD_W-1:0] rdata_out
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [`CSAG_WORD_W-1:0] store [0:255];
   logic [`CSAG_WORD_W-1:0] noise = 16'h1357;

   initial begin
      for (int i = 0; i < 256; i++) begin
         store[i] = {8'hc5, 8'(i)};
      end
   end

   always @(posedge mclk_in) begin
      noise <= noise + 16'h3b1d;
      if (mem_in.en && mem_in.we) begin
         store[mem_in.addr[7:0]] <= mem_in.wdata;
      end
   end

   always_comb begin
      if (!mem_in.en) begin
         // not selected: data bus shows a moving pattern
         rdata_out = noise;
      end else if (mem_in.addr >= 22'h3f7f80 && mem_in.addr <= 22'h3f7ff5) begin
         rdata_out = 16'h0000;
      end else begin
         rdata_out = store[mem_in.addr[7:0]];
      end
   end
endmodule

// *** test/tb_csag_gate.sv ***
`include "csag_consts.svh"

module tb_csag_gate
   import csag_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   localparam logic [127:0] KEY = 128'h8888_7777_6666_5555_4444_3333_2222_1111;
   logic mclk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic [127:0] pwd = KEY;
   logic pwd_rd = 1'b0;
   logic [2:0] pwd_idx = 3'h0;
   logic wen = 1'b0;
   logic key_wr = 1'b0;
   logic [2:0] key_idx = 3'h0;
   logic [15:0] key_d = 16'h0000;
   logic ctrl_wr = 1'b0;
   logic [15:0] ctrl_d = 16'h0000;
   csag_req_t req = '0;
   csag_mem_t mem;
   logic [15:0] mem_rd;
   logic [15:0] rdata;
   logic [15:0] status;
   logic rvalid;
   logic denied;
   logic locked;
   logic [15:0] shadow [0:255];
   int failures = 0;
   int compares = 0;
   int cycles = 0;

   csag_gate u_csag_gate (
      .mclk_in(mclk_in),
      .rstn_in(rstn_in),
      .password_in(pwd),
      .pwd_read_in(pwd_rd),
      .pwd_index_in(pwd_idx),
      .protected_write_enable_in(wen),
      .key_write_in(key_wr),
      .key_index_in(key_idx),
      .key_data_in(key_d),
      .ctrl_write_in(ctrl_wr),
      .ctrl_data_in(ctrl_d),
      .req_in(req),
      .mem_out(mem),
      .mem_rdata_in(mem_rd),
      .rdata_out(rdata),
      .rvalid_out(rvalid),
      .denied_out(denied),
      .status_out(status),
      .locked_out(locked)
   );

   csag_mem_model u_csag_mem_model (
      .mclk_in(mclk_in),
      .mem_in(mem),
      .rdata_out(mem_rd)
   );

   always #50 mclk_in = ~mclk_in;

   always @(posedge mclk_in) begin
      cycles++;
      if (cycles == 2000) begin
         failures++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("failures=%0d compares=%0d", failures, compares);
      if (failures == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge mclk_in);
      #10;
   endtask

   task automatic rst(input logic [127:0] p);
      pwd = p;
      rstn_in = 1'b0;
      step(6);
      rstn_in = 1'b1;
   endtask

   task automatic st(input logic lk);
      chk(locked, 16'(lk));
      chk(status, {9'h000, 6'h17, lk});
   endtask

   // fetch, write, debug, from secure, target secure, address, granted
   task automatic acc(input logic f, w, d, fs, ts, input logic [7:0] a, input logic g);
      logic [15:0] wd;
      wd = {a, ~a};
      step(1);
      req = '{1'b1, f, w, d, fs, ts, {14'h0001, a}, wd};
      #1;
      chk(mem.en, 16'(g));
      chk(mem.we, 16'(g & w));
      step(1);
      req.valid = 1'b0;
      chk(denied, 16'(!g));
      chk(rvalid, 16'(!w));
      chk(rdata, (g && !w) ? shadow[a] : 16'h0000);
      if (g && w) begin
         shadow[a] = wd;
      end
   endtask

   task automatic pwd_reads();
      for (int i = 7; i >= 0; i--) begin
         step(1);
         pwd_rd = 1'b1;
         pwd_idx = 3'(i);
      end
      step(1);
      pwd_rd = 1'b0;
   endtask

   task automatic keys(input logic [127:0] k, input logic en);
      for (int i = 0; i < 8; i++) begin
         step(1);
         wen = en;
         key_wr = 1'b1;
         key_idx = 3'(i);
         key_d = k[16*i +: 16];
      end
      step(1);
      key_wr = 1'b0;
      wen = 1'b0;
   endtask

   task automatic force_lock(input logic en);
      step(1);
      wen = en;
      ctrl_wr = 1'b1;
      ctrl_d = 16'h8000;
      step(1);
      ctrl_wr = 1'b0;
      wen = 1'b0;
   endtask

   initial begin
      for (int i = 0; i < 256; i++) begin
         shadow[i] = {8'hc5, 8'(i)};
      end
      rst(KEY);
      st(1'b1);
      acc(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 8'h10, 1'b1);
      acc(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 8'h11, 1'b0);
      acc(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 8'h12, 1'b0);
      acc(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 8'h12, 1'b0);
      acc(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 8'h12, 1'b1);
      acc(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 8'h13, 1'b1);
      acc(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 8'h13, 1'b0);
      acc(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 8'h14, 1'b0);
      acc(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h13, 1'b1);
      keys(KEY, 1'b1);
      pwd_reads();
      step(2);
      st(1'b1);
      keys(KEY ^ 128'h1, 1'b1);
      step(1);
      st(1'b1);
      keys(KEY, 1'b0);
      step(1);
      st(1'b1);
      keys(KEY, 1'b1);
      step(1);
      st(1'b0);
      acc(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 8'h12, 1'b1);
      acc(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 8'h15, 1'b1);
      acc(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 8'h15, 1'b1);
      force_lock(1'b0);
      st(1'b0);
      force_lock(1'b1);
      st(1'b1);
      acc(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 8'h15, 1'b0);
      keys(KEY, 1'b1);
      step(1);
      st(1'b1);
      rst({128{1'b1}});
      st(1'b1);
      pwd_reads();
      st(1'b0);
      rst(128'h0);
      pwd_reads();
      keys(128'h0, 1'b1);
      step(2);
      st(1'b1);
      end_of_test();
   end
endmodule
